// *** src/aifd_pkg.sv ***
// package: register map, field layouts and types of the input function dispatcher
// Functional notes
// - home edge starts homing; runs to completion
// - priority target runs only while held
// - priority target beaten only by host motion
// - priority target needs origin established flag
// - origin set loads position, sets origin flag
// - origin set during a running held move, or in analog or remote position mode, re-references target
// - fault clear edge drops only gone faults
// - brake override releases brake while disabled
// - four select bits pick move; unassigned zero
// - indexed held move follows index immediately
// - indexed held beats numbered held and pulses
// - indexed pulse move locks inputs until done
// - released held move stops, resumes on reassert
// - lowest held wins; held beats pulse
// - pulse edge starts move only when idle
// - capture edge stores position when armed
// - captured positions saved to non-volatile store
// - level terminators end feed on level
// - edge terminators end feed on edge
// - alternate select routes alternate analog quantity
// - calibration request edge launches calibration
// - held incremental move restarts after completion
package aifd_pkg;

  localparam int AIFD_NMOVE = 16; // moves and capture slots
  localparam int AIFD_NFLT = 8; // latched fault flags
  localparam int AIFD_NLVL = 8; // terminators 1..8 act on level, 9..16 on edge
  localparam int AIFD_AW = 8; // register address width
  localparam int AIFD_DW = 32; // register data width

  // register byte offsets
  localparam logic [7:0] AIFD_OFF_CTRL = 8'h00;
  localparam logic [7:0] AIFD_OFF_TERM_ASSIGN = 8'h04;
  localparam logic [7:0] AIFD_OFF_TERM_POL = 8'h08;
  localparam logic [7:0] AIFD_OFF_STATUS = 8'h0C;
  localparam logic [7:0] AIFD_OFF_ORIGIN = 8'h10;
  localparam logic [1:0] AIFD_TGT_PAGE = 2'h1; // targets at 0x40 + 4*n

  // reset values
  localparam logic [3:0] AIFD_SEL_ASSIGN_RST = 4'hF;
  localparam logic AIFD_TEACH_ALWAYS_RST = 1'b0;
  localparam logic [15:0] AIFD_TERM_ASSIGN_RST = 16'h0000;
  localparam logic [15:0] AIFD_TERM_POL_RST = 16'hFFFF;

  // digital input functions, one bit each
  typedef struct packed {
    logic home; // homing trigger
    logic prio; // priority target request
    logic origin_set; // origin set command
    logic teach_arm; // capture arm
    logic fault_clr; // fault clear request
    logic brake_ovr; // brake release force
    logic [3:0] sel; // move index bits
    logic idx_held; // indexed held motion
    logic idx_pulse; // indexed pulse motion
    logic [15:0] held; // per-number held motions
    logic [15:0] pulse; // per-number pulse motions
    logic [15:0] capture; // per-number capture points
    logic [15:0] term; // feed terminator switches
    logic aout_alt; // analog output alternate select
    logic cal; // travel calibration request
  } aifd_fn_s;
  localparam int AIFD_FN_W = $bits(aifd_fn_s);

  // motion request towards the profile generator
  typedef struct packed {
    logic go; // run (1) or decelerate and hold (0)
    logic held; // held-type source
    logic [3:0] num; // selected move
  } aifd_mreq_s;

  // control register layout
  typedef struct packed {
    logic [26:0] rsvd;
    logic [3:0] sel_assign; // which index bits are wired
    logic teach_always; // capture armed without input
  } aifd_ctrl_s;

  // status register layout
  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] faults;
    logic [3:0] rsvd_mid;
    logic [3:0] num;
    logic [1:0] rsvd_lo;
    logic held;
    logic go;
    logic pulse_lock;
    logic prio;
    logic origin_valid;
    logic homing;
  } aifd_stat_s;

  // motion source arbitration states
  typedef enum logic [5:0] {
    AIFD_S_IDLE = 6'h01,
    AIFD_S_HOST = 6'h02,
    AIFD_S_PRIO = 6'h04,
    AIFD_S_IDX = 6'h08,
    AIFD_S_NUM = 6'h10,
    AIFD_S_PULSE = 6'h20
  } aifd_src_e;

endpackage

// *** src/aifd_top.sv ***
// module: input function dispatcher turning digital input functions into motion requests
`timescale 1ns/1ps
`default_nettype none
module aifd_top import aifd_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [AIFD_FN_W-1:0] fn_pins, // raw input functions, asynchronous
  input wire logic [31:0] cur_pos, // current position
  input wire logic move_done, // running move completed
  input wire logic home_done, // homing sequence completed
  input wire logic motion_busy, // any move currently running
  input wire logic host_motion, // remote command mode commands motion
  input wire logic analog_pos_mode, // analog position mode active
  input wire logic host_pos_mode, // remote position mode active
  input wire logic drive_enabled, // power stage active
  input wire logic term_move, // running move ends on terminator
  input wire logic [AIFD_NFLT-1:0] fault_cond, // live fault conditions
  input wire logic [AIFD_AW-1:0] reg_addr,
  input wire logic [AIFD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [AIFD_DW-1:0] reg_rdata,
  output logic home_start, // pulse: begin homing
  output logic homing, // homing sequence in progress
  output logic origin_valid, // origin established
  output logic [31:0] origin_offset, // origin offset value
  output logic prio_run, // priority target motion active
  output aifd_mreq_s move_req, // selected move request
  output logic move_start, // pulse: (re)start selected move
  output logic reref, // pulse: re-reference command to new origin
  output logic feed_end, // end feed of running move: one cycle for an edge terminator, held while a level terminator stays active
  output logic brake_release, // force internal brake released
  output logic aout_alt_sel, // analog output shows alternate quantity
  output logic cal_start, // pulse: launch travel calibration
  output logic [AIFD_NFLT-1:0] fault_flags, // latched faults
  output logic nv_save, // pulse: store captured target
  output logic [3:0] nv_addr, // slot being stored
  output logic [31:0] nv_data // value being stored
);

  logic [AIFD_FN_W-1:0] fn_s1_q; // first sync stage, read only by second
  logic [AIFD_FN_W-1:0] fn_s2_q; // synchronised inputs
  logic [AIFD_FN_W-1:0] fn_p_q; // previous synchronised sample
  logic [AIFD_FN_W-1:0] rise_v; // rising edge pulses
  logic [AIFD_FN_W-1:0] fall_v; // falling edge pulses
  aifd_fn_s fn; // level view
  aifd_fn_s fr; // rising edge view
  aifd_fn_s ff; // falling edge view

  logic teach_always_q; // capture always armed
  logic [3:0] sel_assign_q; // index bits that are wired
  logic [15:0] term_assign_q; // terminators in use
  logic [15:0] term_pol_q; // active level or edge direction
  logic [31:0] target_mem [AIFD_NMOVE]; // captured targets

  aifd_src_e src_q; // current motion source
  aifd_src_e src_d;
  logic [3:0] num_d;
  logic go_d;
  logic held_d;
  logic pulse_lock_q; // pulse move running, inputs locked
  logic pulse_lock_d;
  logic [3:0] sel_eff; // index with unwired bits at zero
  logic pulse_fire; // some pulse edge this cycle
  logic [3:0] pulse_num; // move the pulse edge asks for
  logic teach_hit; // armed capture edge this cycle
  logic [3:0] teach_num; // slot to capture
  logic term_hit; // terminator condition seen
  aifd_ctrl_s ctrl_rd; // control register readback
  aifd_stat_s stat_rd; // status register readback

  // lowest set bit of a 16 bit vector
  function automatic logic [3:0] aifd_lowest(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // two-stage synchroniser plus one history stage for edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fn_s1_q <= '0;
      fn_s2_q <= '0;
      fn_p_q <= '0;
    end else begin
      fn_s1_q <= fn_pins;
      fn_s2_q <= fn_s1_q;
      fn_p_q <= fn_s2_q;
    end
  end

  // one edge detector per input function
  for (genvar gi = 0; gi < AIFD_FN_W; gi++) begin : g_edge
    assign rise_v[gi] = fn_s2_q[gi] & ~fn_p_q[gi];
    assign fall_v[gi] = ~fn_s2_q[gi] & fn_p_q[gi];
  end
  // struct views of the flat vectors, so logic below reads by field name
  assign fn = fn_s2_q;
  assign fr = rise_v;
  assign ff = fall_v;

  // unwired index bits read as zero, so a partly wired index still works
  assign sel_eff = fn.sel & sel_assign_q;

  // pulse request: indexed pulse first, then lowest numbered pulse edge
  assign pulse_fire = fr.idx_pulse | (|fr.pulse);
  assign pulse_num = fr.idx_pulse ? sel_eff : aifd_lowest(fr.pulse);

  // capture armed by input or by the always-armed option
  assign teach_hit = (|fr.capture) & (fn.teach_arm | teach_always_q);
  assign teach_num = aifd_lowest(fr.capture);

  // level terminators 1..8 and edge terminators 9..16
  assign term_hit = |(term_assign_q[AIFD_NLVL-1:0]
    & ~(fn.term[AIFD_NLVL-1:0] ^ term_pol_q[AIFD_NLVL-1:0]))
    | |(term_assign_q[15:AIFD_NLVL] & ((fr.term[15:AIFD_NLVL] & term_pol_q[15:AIFD_NLVL])
    | (ff.term[15:AIFD_NLVL] & ~term_pol_q[15:AIFD_NLVL])));

  // software writes to configuration registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      teach_always_q <= AIFD_TEACH_ALWAYS_RST;
      sel_assign_q <= AIFD_SEL_ASSIGN_RST;
      term_assign_q <= AIFD_TERM_ASSIGN_RST;
      term_pol_q <= AIFD_TERM_POL_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        AIFD_OFF_CTRL: begin
          teach_always_q <= reg_wdata[0];
          sel_assign_q <= reg_wdata[4:1];
        end
        AIFD_OFF_TERM_ASSIGN: term_assign_q <= reg_wdata[15:0];
        AIFD_OFF_TERM_POL: term_pol_q <= reg_wdata[15:0];
        default: ; // read-only or unmapped, write ignored
      endcase
    end
  end

  // register readback images
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd.teach_always = teach_always_q;
    ctrl_rd.sel_assign = sel_assign_q;
    stat_rd = '0;
    stat_rd.homing = homing;
    stat_rd.origin_valid = origin_valid;
    stat_rd.prio = prio_run;
    stat_rd.pulse_lock = pulse_lock_q;
    stat_rd.go = move_req.go;
    stat_rd.held = move_req.held;
    stat_rd.num = move_req.num;
    stat_rd.faults = fault_flags;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr[7:6] == AIFD_TGT_PAGE) begin
      reg_rdata <= target_mem[reg_addr[5:2]];
    end else begin
      unique case (reg_addr)
        AIFD_OFF_CTRL: reg_rdata <= ctrl_rd;
        AIFD_OFF_TERM_ASSIGN: reg_rdata <= {16'h0000, term_assign_q};
        AIFD_OFF_TERM_POL: reg_rdata <= {16'h0000, term_pol_q};
        AIFD_OFF_STATUS: reg_rdata <= stat_rd;
        AIFD_OFF_ORIGIN: reg_rdata <= origin_offset;
        default: reg_rdata <= '0; // unmapped reads zero
      endcase
    end
  end

  // homing: the edge starts it, the trigger level no longer matters after
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      homing <= 1'b0;
      home_start <= 1'b0;
    end else begin
      home_start <= fr.home;
      if (fr.home) begin
        homing <= 1'b1;
      end else if (home_done) begin
        homing <= 1'b0;
      end
    end
  end

  // origin: origin-set works at any time, even mid motion
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      origin_valid <= 1'b0;
      origin_offset <= '0;
      reref <= 1'b0;
    end else begin
      reref <= fr.origin_set & ((move_req.held & move_req.go) | analog_pos_mode
        | host_pos_mode);
      if (fr.origin_set) begin
        origin_offset <= cur_pos;
        origin_valid <= 1'b1;
      end else if (home_done & homing) begin
        origin_valid <= 1'b1;
      end else if (fr.home) begin
        origin_valid <= 1'b0; // a new homing run voids the old origin
      end
    end
  end

  // source arbitration, highest first
  always_comb begin
    src_d = AIFD_S_IDLE;
    num_d = move_req.num;
    go_d = 1'b0;
    held_d = 1'b0;
    // a finished pulse move frees the lock; a new edge is then needed
    pulse_lock_d = pulse_lock_q & ~move_done;
    if (host_motion) begin
      src_d = AIFD_S_HOST;
    end else if (fn.prio & origin_valid) begin
      src_d = AIFD_S_PRIO;
    end else if (fn.idx_held) begin
      src_d = AIFD_S_IDX;
      num_d = sel_eff;
      go_d = 1'b1;
      held_d = 1'b1;
    end else if (|fn.held) begin
      src_d = AIFD_S_NUM;
      num_d = aifd_lowest(fn.held);
      go_d = 1'b1;
      held_d = 1'b1;
    end else if (pulse_lock_d & (src_q == AIFD_S_PULSE)) begin
      src_d = AIFD_S_PULSE;
      go_d = 1'b1;
    end else if (pulse_fire & ~motion_busy & ~pulse_lock_q) begin
      src_d = AIFD_S_PULSE;
      num_d = pulse_num;
      go_d = 1'b1;
      pulse_lock_d = 1'b1;
    end else if (src_q == AIFD_S_NUM) begin
      src_d = AIFD_S_NUM;
      held_d = 1'b1;
    end
    // a held source taking over frees the pulse lock
    if (src_d != AIFD_S_PULSE) begin
      pulse_lock_d = 1'b0;
    end
  end

  // source state and request outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      src_q <= AIFD_S_IDLE;
      pulse_lock_q <= 1'b0;
      move_req <= '0;
      prio_run <= 1'b0;
      move_start <= 1'b0;
    end else begin
      src_q <= src_d;
      pulse_lock_q <= pulse_lock_d;
      move_req.num <= num_d;
      move_req.go <= go_d;
      move_req.held <= held_d;
      prio_run <= (src_d == AIFD_S_PRIO);
      // new choice, resume after hold, or held restart after done
      move_start <= go_d & ((src_d != src_q) | (num_d != move_req.num) | ~move_req.go
        | (held_d & move_done));
    end
  end

  // fault flags: a live condition always wins over the clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fault_flags <= '0;
    end else begin
      fault_flags <= (fault_flags & ~({AIFD_NFLT{fr.fault_clr}} & ~fault_cond))
        | fault_cond;
    end
  end

  // brake, analog route, calibration and feed end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      brake_release <= 1'b0;
      aout_alt_sel <= 1'b0;
      cal_start <= 1'b0;
      feed_end <= 1'b0;
    end else begin
      brake_release <= fn.brake_ovr & ~drive_enabled;
      aout_alt_sel <= fn.aout_alt;
      cal_start <= fr.cal;
      feed_end <= term_move & motion_busy & term_hit;
    end
  end

  // captured targets; each capture is also pushed to non-volatile storage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < AIFD_NMOVE; i++) begin
        target_mem[i] <= '0;
      end
      nv_save <= 1'b0;
      nv_addr <= '0;
      nv_data <= '0;
    end else begin
      nv_save <= teach_hit;
      if (teach_hit) begin
        target_mem[teach_num] <= cur_pos;
        nv_addr <= teach_num;
        nv_data <= cur_pos;
      end
    end
  end

  // checks on the dispatcher's own outputs
  a_home_start_edge: assert property (@(posedge core_clk) disable iff (!resetn)
    fr.home |=> home_start && homing) else $error("homing not started by edge");

  a_home_runs_on: assert property (@(posedge core_clk) disable iff (!resetn)
    homing && !home_done && !fr.home |=> homing) else $error("homing dropped early");

  a_prio_needs_origin: assert property (@(posedge core_clk) disable iff (!resetn)
    prio_run |-> $past(origin_valid) && $past(fn.prio)) else $error("prio without origin");

  a_prio_release: assert property (@(posedge core_clk) disable iff (!resetn)
    !fn.prio |=> !prio_run) else $error("prio ran without request");

  a_host_beats_prio: assert property (@(posedge core_clk) disable iff (!resetn)
    host_motion |=> !prio_run) else $error("prio ran under host");

  a_origin_load: assert property (@(posedge core_clk) disable iff (!resetn)
    fr.origin_set |=> origin_valid && origin_offset == $past(cur_pos))
    else $error("origin not loaded");

  // fault flags: live conditions stay, gone ones drop on a clear
  a_fault_keep: assert property (@(posedge core_clk) disable iff (!resetn)
    1'b1 |=> (fault_flags & $past(fault_cond)) == $past(fault_cond))
    else $error("live fault cleared");

  a_fault_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    fr.fault_clr |=> (fault_flags & ~$past(fault_cond)) == '0)
    else $error("dead fault kept");

  a_brake_force: assert property (@(posedge core_clk) disable iff (!resetn)
    fn.brake_ovr && !drive_enabled |=> brake_release) else $error("brake not released");

  a_aout_route: assert property (@(posedge core_clk) disable iff (!resetn)
    fn.aout_alt |=> aout_alt_sel) else $error("alternate output not routed");

  // move selection, feed end, calibration and capture checks
  a_pulse_locked: assert property (@(posedge core_clk) disable iff (!resetn)
    src_q == AIFD_S_PULSE && src_d == AIFD_S_PULSE |=> $stable(move_req.num))
    else $error("pulse move changed mid run");

  a_pulse_idle: assert property (@(posedge core_clk) disable iff (!resetn)
    move_start && !move_req.held |-> !$past(motion_busy))
    else $error("pulse move started while busy");

  a_held_lowest: assert property (@(posedge core_clk) disable iff (!resetn)
    !host_motion && !(fn.prio && origin_valid) && !fn.idx_held && fn.held[2:0] == 3'b100
    |=> move_req.num == 4'h2 && move_req.go) else $error("lowest held not chosen");

  a_feed_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    !term_move |=> !feed_end) else $error("feed ended outside terminator move");

  a_cal_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
    fr.cal |=> cal_start ##1 !cal_start) else $error("calibration start not a pulse");

  a_capture_save: assert property (@(posedge core_clk) disable iff (!resetn)
    teach_hit |=> nv_save && nv_data == $past(cur_pos)) else $error("capture not saved");

endmodule // aifd_top
`default_nettype wire

// *** verification/aifd_bench.sv ***
// testbench: drives input functions and registers of the dispatcher
`timescale 1ns/1ps
`default_nettype none
module aifd_bench import aifd_pkg::*; ;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  aifd_fn_s fn = '0; // input function pins
  logic [31:0] cur_pos = '0;
  logic host_motion = 1'b0, analog_pos_mode = 1'b0, host_pos_mode = 1'b0;
  logic drive_enabled = 1'b0, term_move = 1'b0;
  logic [7:0] fault_cond = '0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata, origin_offset, nv_data, d;
  logic home_start, homing, origin_valid, prio_run, move_start, reref, feed_end;
  logic brake_release, aout_alt_sel, cal_start, nv_save, motion_busy, move_done, home_done;
  logic [7:0] fault_flags;
  logic [3:0] nv_addr;
  aifd_mreq_s move_req;
  int err_count = 0, samples_checked = 0, ms_n = 0, fe_n = 0, n0;

  // free running 100 MHz clock
  always #5 core_clk = ~core_clk;
  // event counters for pulses whose exact cycle is not fixed
  always @(posedge core_clk) begin
    if (move_start === 1'b1) ms_n++;
    if (feed_end === 1'b1) fe_n++;
  end

  aifd_top uut (.core_clk(core_clk), .resetn(resetn), .fn_pins(fn), .cur_pos(cur_pos),
    .move_done(move_done), .home_done(home_done), .motion_busy(motion_busy),
    .host_motion(host_motion), .analog_pos_mode(analog_pos_mode),
    .host_pos_mode(host_pos_mode), .drive_enabled(drive_enabled), .term_move(term_move),
    .fault_cond(fault_cond), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .home_start(home_start), .homing(homing),
    .origin_valid(origin_valid), .origin_offset(origin_offset), .prio_run(prio_run),
    .move_req(move_req), .move_start(move_start), .reref(reref), .feed_end(feed_end),
    .brake_release(brake_release), .aout_alt_sel(aout_alt_sel), .cal_start(cal_start),
    .fault_flags(fault_flags), .nv_save(nv_save), .nv_addr(nv_addr), .nv_data(nv_data));

  // far side answering starts with busy and done
  aifd_motion_model #(.RUN(20)) model (.core_clk(core_clk), .resetn(resetn),
    .move_start(move_start), .home_start(home_start), .motion_busy(motion_busy),
    .move_done(move_done), .home_done(home_done));

  // one compare for every result; values widened to a word
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // wait n edges, then look once outputs have settled
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task tdone(input string nm);
    $display("test %s done", nm);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100us;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    chk("idle outs", 0, {homing, origin_valid, prio_run, move_start, brake_release});
    resetn <= 1'b1;
    // register reset values, masked and refused writes, unmapped read
    rd(AIFD_OFF_CTRL, d); chk("ctrl", 32'h0000001E, d);
    rd(AIFD_OFF_TERM_ASSIGN, d); chk("term_assign", 32'h00000000, d);
    rd(AIFD_OFF_TERM_POL, d); chk("term_pol", 32'h0000FFFF, d);
    wr(AIFD_OFF_TERM_POL, 32'hFFFF0F0F);
    rd(AIFD_OFF_TERM_POL, d); chk("term_pol rw", 32'h00000F0F, d);
    wr(AIFD_OFF_ORIGIN, 32'hFFFFFFFF);
    rd(AIFD_OFF_ORIGIN, d); chk("origin ro", 32'h00000000, d);
    rd(8'h24, d); chk("unmapped", 32'h00000000, d);
    tdone("registers");
    // priority request refused before an origin exists
    @(posedge core_clk); fn.prio <= 1'b1; cyc(4);
    chk("prio no origin", 0, prio_run);
    @(posedge core_clk); fn.prio <= 1'b0; cyc(4);
    tdone("prio refused");
    // homing keeps running after the trigger drops
    @(posedge core_clk); fn.home <= 1'b1; cyc(3);
    chk("home_start", 1, home_start);
    @(posedge core_clk); fn.home <= 1'b0; cyc(8);
    chk("homing held", 1, homing);
    cyc(20);
    chk("homing end", 0, homing);
    chk("homed", 1, origin_valid);
    tdone("home");
    // origin set loads the present position
    @(posedge core_clk); cur_pos <= 32'h00001234; fn.origin_set <= 1'b1; cyc(3);
    chk("origin_offset", 32'h00001234, origin_offset);
    rd(AIFD_OFF_ORIGIN, d); chk("origin reg", 32'h00001234, d);
    @(posedge core_clk); fn.origin_set <= 1'b0; cyc(3);
    tdone("origin");
    // priority target held, then beaten by host motion
    @(posedge core_clk); fn.prio <= 1'b1; cyc(3);
    chk("prio run", 1, prio_run);
    @(posedge core_clk); host_motion <= 1'b1; cyc(4);
    chk("prio vs host", 0, prio_run);
    @(posedge core_clk); host_motion <= 1'b0; cyc(4);
    @(posedge core_clk); fn.prio <= 1'b0; cyc(4);
    chk("prio released", 0, prio_run);
    tdone("prio");
    // pulse move, refused second pulse, edge terminator
    wr(AIFD_OFF_TERM_ASSIGN, 32'h00000101);
    @(posedge core_clk); term_move <= 1'b1; fn.pulse[5] <= 1'b1; cyc(3);
    chk("pulse req", 32'h25, move_req);
    chk("pulse start", 1, move_start);
    @(posedge core_clk); fn.pulse[3] <= 1'b1; fn.term[8] <= 1'b1; n0 = fe_n; cyc(5);
    chk("busy pulse", 32'h25, move_req);
    chk("edge term", 1, fe_n - n0);
    cyc(6);
    chk("no level end", 1, fe_n - n0);
    @(posedge core_clk); fn.term[0] <= 1'b1; n0 = fe_n; cyc(5);
    chk("level term", 2, fe_n - n0);
    cyc(14);
    chk("pulse done", 0, move_req.go);
    @(posedge core_clk); fn.pulse <= '0; fn.term <= '0; term_move <= 1'b0; cyc(4);
    tdone("pulse");
    // indexed pulse locks the index until completion
    @(posedge core_clk); fn.sel <= 4'h2; fn.idx_pulse <= 1'b1; cyc(3);
    chk("idx pulse", 32'h22, move_req);
    @(posedge core_clk); fn.sel <= 4'h6; cyc(3);
    chk("idx locked", 32'h22, move_req);
    @(posedge core_clk); fn.idx_pulse <= 1'b0; cyc(30);
    tdone("index pulse");
    // held moves: lowest wins, beats pulses, restarts, indexed held
    @(posedge core_clk); fn.held <= 16'h0084; cyc(3);
    chk("held low", 32'h32, move_req);
    @(posedge core_clk); fn.pulse[1] <= 1'b1; cyc(3);
    chk("held vs pulse", 32'h32, move_req);
    @(posedge core_clk); fn.origin_set <= 1'b1; cyc(3);
    chk("reref", 1, reref);
    n0 = ms_n;
    cyc(30);
    chk("restart", 1, ms_n > n0);
    @(posedge core_clk); fn.sel <= 4'h9; fn.idx_held <= 1'b1; cyc(3);
    chk("idx held", 32'h39, move_req);
    @(posedge core_clk); fn.sel <= 4'h3; cyc(3);
    chk("idx follow", 32'h33, move_req);
    wr(AIFD_OFF_CTRL, 32'h0000000E);
    @(posedge core_clk); fn.sel <= 4'h9; cyc(3);
    chk("sel unassigned", 32'h31, move_req);
    wr(AIFD_OFF_CTRL, 32'h0000001E);
    @(posedge core_clk); fn.idx_held <= 1'b0; fn.held <= 16'h0004; cyc(3);
    @(posedge core_clk); fn.held <= '0; cyc(3);
    chk("held pause", 32'h02, {move_req.go, move_req.num});
    rd(AIFD_OFF_STATUS, d); chk("status", 32'h00000222, d);
    @(posedge core_clk); fn.held <= 16'h0004; cyc(3);
    chk("held resume", 32'h12, {move_req.go, move_req.num});
    chk("resume start", 1, move_start);
    @(posedge core_clk); fn <= '0; cyc(30);
    tdone("held");
    // faults clear only where the condition has gone
    @(posedge core_clk); fault_cond <= 8'h03; cyc(2);
    @(posedge core_clk); fault_cond <= 8'h01; cyc(2);
    chk("faults latched", 32'h03, fault_flags);
    @(posedge core_clk); fn.fault_clr <= 1'b1; cyc(4);
    chk("faults cleared", 32'h01, fault_flags);
    @(posedge core_clk); fault_cond <= '0; fn.fault_clr <= 1'b0; cyc(3);
    tdone("faults");
    // brake override, analog select, calibration
    @(posedge core_clk); fn.brake_ovr <= 1'b1; fn.aout_alt <= 1'b1; fn.cal <= 1'b1; cyc(3);
    chk("brake off", 1, brake_release);
    chk("aout alt", 1, aout_alt_sel);
    chk("cal start", 1, cal_start);
    @(posedge core_clk); drive_enabled <= 1'b1; cyc(3);
    chk("brake enabled", 0, brake_release);
    chk("cal once", 0, cal_start);
    @(posedge core_clk); fn <= '0; cyc(4);
    tdone("misc");
    // capture needs the arm, then stores and saves the position
    @(posedge core_clk); cur_pos <= 32'h0000ABCD; fn.capture[4] <= 1'b1; cyc(3);
    chk("unarmed", 0, nv_save);
    @(posedge core_clk); fn.capture <= '0; fn.teach_arm <= 1'b1; cyc(3);
    @(posedge core_clk); fn.capture[4] <= 1'b1; cyc(3);
    chk("nv_save", 1, nv_save);
    chk("nv slot", 4, nv_addr);
    chk("nv value", 32'h0000ABCD, nv_data);
    rd(8'h50, d); chk("target 4", 32'h0000ABCD, d);
    tdone("capture");
    end_sim();
  end
endmodule // aifd_bench
`default_nettype wire

// *** verification/aifd_motion_model.sv ***
// motion side model: answers move and homing starts after a fixed run time
`timescale 1ns/1ps
`default_nettype none
module aifd_motion_model #(
  parameter int RUN = 20 // cycles a move or a homing run lasts
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic move_start,
  input wire logic home_start,
  output logic motion_busy,
  output logic move_done,
  output logic home_done
);
  int mcnt; // move cycles left
  int hcnt; // homing cycles left
  // a restart while busy reloads the run time, as a real profile would
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mcnt <= 0;
      hcnt <= 0;
    end else begin
      if (move_start === 1'b1) mcnt <= RUN;
      else if (mcnt != 0) mcnt <= mcnt - 1;
      if (home_start === 1'b1) hcnt <= RUN;
      else if (hcnt != 0) hcnt <= hcnt - 1;
    end
  end
  // done pulses land in the last cycle of each run
  assign motion_busy = (mcnt != 0);
  assign move_done = (mcnt == 1);
  assign home_done = (hcnt == 1);
endmodule // aifd_motion_model
`default_nettype wire
